// *** bench/irq_controller_assertions.sv ***
// Checker of the acceptance, return and fetch timing at the controller's ports.
`timescale 1ns/1ns
module irq_controller_assertions
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        soft_trap_exec,
    input wire logic        maskable_return,
    input wire logic [15:0] sp_now,
    input wire logic        fetch_valid,
    input wire logic        fetch_nonexistent,
    input wire logic        fetch_in_data_area,
    input wire logic        trap_as_interrupt,
    input wire logic [7:0]  mem_rdata,
    input wire logic [7:0]  fetch_data,
    input wire logic        trap_reset_req,
    input wire logic        accept_busy,
    input wire logic        stack_write,
    input wire logic [15:0] stack_addr,
    input wire logic [15:0] sp_load,
    input wire logic        sp_load_en,
    input wire logic [15:0] vector_addr,
    input wire logic        pc_load_en,
    input wire logic        psw_restore_en,
    input wire logic        accept_ack
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // The acceptance holds the core for eight cycles and pushes three bytes in a row.
    sequence s_seq8;
        accept_busy [*8] ##1 !accept_busy;
    endsequence
    sequence s_push3;
        stack_write [*3] ##1 !stack_write;
    endsequence

    a_ack_first: assert property ($rose(accept_busy) |-> accept_ack)
        else $error("acknowledge missing at sequence start");
    a_seq_eight: assert property ($rose(accept_busy) |-> s_seq8)
        else $error("acceptance not eight cycles");
    a_push_three: assert property ($rose(stack_write) |-> s_push3)
        else $error("stack push not three bytes");
    a_push_down: assert property (stack_write && $past(stack_write)
        |-> stack_addr == $past(stack_addr) - 16'h0001)
        else $error("stack push address not descending");
    a_sp_drop: assert property (sp_load_en && stack_write
        |-> sp_load == stack_addr - 16'h0001)
        else $error("stack pointer not lowered by three");
    a_vector_load: assert property (pc_load_en
        |-> accept_busy && !vector_addr[0] && vector_addr >= 16'hFFE0)
        else $error("vector outside table");
    a_soft_start: assert property (soft_trap_exec && !accept_busy |=> accept_ack)
        else $error("soft trap not started at once");
    a_ret_restore: assert property (maskable_return |-> ##[1:3] psw_restore_en)
        else $error("return did not restore status");
    a_ret_sp_up: assert property (psw_restore_en
        |=> sp_load_en && sp_load == $past(sp_now) + 16'h0003)
        else $error("return did not raise stack pointer by three");
    a_fetch_ff: assert property (fetch_data == (fetch_nonexistent ? 8'hFF : mem_rdata))
        else $error("fetch data wrong");
    a_trap_reset: assert property (trap_reset_req
        == (fetch_valid && fetch_in_data_area && !trap_as_interrupt))
        else $error("address trap reset wrong");
endmodule

bind irq_controller irq_controller_assertions i_irq_controller_assertions (.*);

// *** bench/irq_core_model.sv ***
// Behavioural model of the CPU core that sits opposite the interrupt controller.
`timescale 1ns/1ns
module irq_core_model
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        accept_busy,
    input  wire logic        stack_write,
    input  wire logic [15:0] stack_addr,
    input  wire logic [7:0]  stack_wdata,
    input  wire logic [15:0] sp_load,
    input  wire logic        sp_load_en,
    input  wire logic [15:0] vector_addr,
    input  wire logic        pc_load_en,
    output logic             instr_last_cycle,
    output logic      [15:0] pc_now,
    output logic      [15:0] sp_now,
    output logic      [7:0]  stack_rdata
);
    logic [7:0] mem [16];
    logic [2:0] step;

    // Instructions end every two or six cycles, never while the core is busy accepting.
    assign instr_last_cycle = (step == 3'h0) && !accept_busy;
    // A return pops the status byte, which sits three above the current stack pointer.
    assign stack_rdata = mem[sp_now[3:0] + 4'h3];

    // Core state follows the loads that the controller asks for.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            step   <= 3'h0;
            pc_now <= 16'h1234;
            sp_now <= 16'h00F0;
        end
        else
        begin
            step <= (step == (slow ? 3'h5 : 3'h1)) ? 3'h0 : step + 3'h1;
            if (pc_load_en) pc_now <= vector_addr;
            if (sp_load_en) sp_now <= sp_load;
            if (stack_write) mem[stack_addr[3:0]] <= stack_wdata;
        end
    end
endmodule

// *** bench/tb.sv ***
// Self-checking bench: registers, latching, masking, nesting, priority and traps.
`timescale 1ns/1ns
module tb
    import irq_ctrl_pkg::*;
;
    logic        clk_sys, rst, reg_write, soft_trap_exec, undef_exec, slow;
    logic        maskable_return, nonmaskable_return, fetch_valid, fetch_nonexistent;
    logic        fetch_in_data_area, trap_as_interrupt, instr_last_cycle, trap_reset_req;
    logic        accept_busy, stack_write, sp_load_en, pc_load_en, psw_restore_en, accept_ack;
    logic [2:0]  shared_factor_select, alt_factor_request;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, program_status_word, stack_rdata;
    logic [7:0]  mem_rdata, fetch_data, stack_wdata, psw_restore;
    logic [15:0] source_request, pc_now, sp_now, stack_addr, sp_load, vector_addr;
    logic [15:0] vec_seen, psw_seen, pcl_seen;
    int          err_count, n_compared, acks, k;

    irq_controller i_irq_controller (.*);
    irq_core_model i_irq_core_model (.*);

    // Free-running system clock.
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    // Record what each acceptance produced; the frame is pushed from 00F0 downward.
    always @(posedge clk_sys)
    begin
        if (accept_ack) acks <= acks + 1;
        if (pc_load_en) vec_seen <= vector_addr;
        if (stack_write && stack_addr == 16'h00F0) psw_seen <= {8'h00, stack_wdata};
        if (stack_write && stack_addr == 16'h00EE) pcl_seen <= {8'h00, stack_wdata};
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk_sys);
        reg_write = 1'b0;
        @(negedge clk_sys);
    endtask

    // Read data is registered, so it is looked at one edge after the address.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        reg_addr = a;
        @(negedge clk_sys);
        chk(what, {8'h00, exp}, {8'h00, reg_rdata});
    endtask

    task automatic req(input logic [15:0] s, input logic [2:0] alt);
        source_request = s;
        alt_factor_request = alt;
        @(negedge clk_sys);
        source_request = 16'h0000;
        alt_factor_request = 3'h0;
    endtask

    task automatic ret(input logic m);
        maskable_return = m;
        nonmaskable_return = !m;
        @(negedge clk_sys);
        maskable_return = 1'b0;
        nonmaskable_return = 1'b0;
        repeat (6) @(negedge clk_sys);
    endtask

    // Waits for the given number of acceptances and the end of the sequence.
    task automatic wait_acc(input int want);
        int i;
        for (i = 0; i < 60 && acks < want; i++) @(negedge clk_sys);
        if (acks < want)
        begin
            err_count++;
            $display("CHECK FAILED accepts expected %0d seen %0d", want, acks);
            test_done();
        end
        for (i = 0; i < 12 && accept_busy !== 1'b0; i++) @(negedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // A hang counts as a mismatch and goes to the verdict.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        $display("CHECK FAILED run expected end seen timeout");
        test_done();
    end

    initial
    begin
        {rst, reg_write, soft_trap_exec, undef_exec, slow, maskable_return} = 6'h20;
        {nonmaskable_return, fetch_valid, fetch_nonexistent, fetch_in_data_area} = 4'h0;
        {trap_as_interrupt, shared_factor_select, alt_factor_request} = 7'h40;
        {reg_addr, reg_wdata, mem_rdata, source_request} = 40'h0;
        program_status_word = 8'hA0;
        {err_count, n_compared} = '0;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        rd(ENABLE_LOW_ADDR, 8'h00, "enable_low reset");
        rd(ENABLE_HIGH_ADDR, 8'h00, "enable_high reset");
        rd(PENDING_LOW_ADDR, 8'h00, "pending_low reset");
        rd(PENDING_HIGH_ADDR, 8'h00, "pending_high reset");
        rd(8'h3E, 8'h00, "unmapped");
        wr(ENABLE_HIGH_ADDR, 8'hA5);
        rd(ENABLE_HIGH_ADDR, 8'hA5, "enable_high");
        wr(ENABLE_HIGH_ADDR, 8'h00);
        req(16'h0020, 3'h0);
        repeat (10) @(negedge clk_sys);
        rd(PENDING_LOW_ADDR, 8'h20, "latch held");
        wr(PENDING_LOW_ADDR, 8'hFF);
        rd(PENDING_LOW_ADDR, 8'h20, "latch after ones");
        wr(PENDING_LOW_ADDR, 8'h00);
        rd(PENDING_LOW_ADDR, 8'h00, "latch after zero");
        $display("test registers and latches done");
        req(16'h0000, 3'h1);
        rd(PENDING_HIGH_ADDR, 8'h00, "unselected alt");
        shared_factor_select = 3'h1;
        req(16'h0200, 3'h0);
        rd(PENDING_HIGH_ADDR, 8'h00, "unselected main");
        req(16'h0000, 3'h1);
        rd(PENDING_HIGH_ADDR, 8'h02, "selected alt");
        wr(PENDING_HIGH_ADDR, 8'h00);
        $display("test shared factor done");
        // Slow instruction boundaries; master stays off while the flags change.
        slow = 1'b1;
        wr(ENABLE_LOW_ADDR, 8'h30);
        wr(ENABLE_HIGH_ADDR, 8'h10);
        req(16'h1020, 3'h0);
        repeat (20) @(negedge clk_sys);
        chk("masked accepts", 16'h0000, 16'(acks));
        wr(ENABLE_LOW_ADDR, 8'h31);
        wait_acc(1);
        chk("vector", VECTOR_TOP - 16'h000A, vec_seen);
        chk("stacked status", 16'h00A1, psw_seen);
        chk("stacked pc low", 16'h0034, pcl_seen);
        rd(ENABLE_LOW_ADDR, 8'h30, "master cleared");
        rd(PENDING_LOW_ADDR, 8'h00, "accepted latch");
        req(16'h0010, 3'h0);
        repeat (20) @(negedge clk_sys);
        chk("nested accepts", 16'h0001, 16'(acks));
        ret(1'b1);
        wait_acc(2);
        chk("vector", VECTOR_TOP - 16'h0008, vec_seen);
        ret(1'b1);
        wait_acc(3);
        chk("vector", VECTOR_TOP - 16'h0018, vec_seen);
        ret(1'b1);
        wr(ENABLE_LOW_ADDR, 8'h00);
        $display("test masking and nesting done");
        // Soft trap, undefined opcode, watchdog and address trap with master off.
        slow = 1'b0;
        for (k = 0; k < 4; k++)
        begin
            {soft_trap_exec, undef_exec, source_request[3], fetch_valid} = 4'h8 >> k;
            fetch_in_data_area = fetch_valid;
            @(negedge clk_sys);
            {soft_trap_exec, undef_exec, source_request[3], fetch_valid} = 4'h0;
            fetch_in_data_area = 1'b0;
            wait_acc(4 + k);
            chk("nonmaskable vector", (k < 2) ? SOFT_VECTOR
                : VECTOR_TOP - ((k == 2) ? 16'h0006 : 16'h0004), vec_seen);
            ret(1'b0);
        end
        trap_as_interrupt = 1'b0;
        {fetch_valid, fetch_in_data_area, fetch_nonexistent} = 3'h7;
        mem_rdata = 8'h5A;
        @(negedge clk_sys);
        chk("trap reset", 16'h0001, {15'h0000, trap_reset_req});
        chk("fetch data", 16'h00FF, {8'h00, fetch_data});
        {fetch_valid, fetch_in_data_area, fetch_nonexistent} = 3'h0;
        $display("test traps done");
        test_done();
    end
endmodule

// *** verilog/irq_controller.sv ***
// Interrupt controller: request latches, enables, factor selection and acceptance sequence.
`timescale 1ns/1ns
module irq_controller
    import irq_ctrl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port from the core.
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Shared-factor selector, one bit per shared source.
    input  wire logic [2:0]  shared_factor_select,
    // Request pulses; bits 9, 14, 15 carry factor A, the alt vector factor B.
    input  wire logic [15:0] source_request,
    input  wire logic [2:0]  alt_factor_request,
    // Core sequencing.
    input  wire logic        instr_last_cycle,
    input  wire logic        soft_trap_exec,
    input  wire logic        undef_exec,
    input  wire logic        maskable_return,
    input  wire logic        nonmaskable_return,
    input  wire logic [15:0] pc_now,
    input  wire logic [15:0] sp_now,
    input  wire logic [7:0]  program_status_word,
    input  wire logic [7:0]  stack_rdata,
    // Fetch checks.
    input  wire logic        fetch_valid,
    input  wire logic        fetch_nonexistent,
    input  wire logic        fetch_in_data_area,
    input  wire logic        trap_as_interrupt,
    input  wire logic [7:0]  mem_rdata,
    output logic      [7:0]  fetch_data,
    output logic             trap_reset_req,
    // Sequence outputs to the core.
    output logic             accept_busy,
    output logic             stack_write,
    output logic      [15:0] stack_addr,
    output logic      [7:0]  stack_wdata,
    output logic      [15:0] sp_load,
    output logic             sp_load_en,
    output logic      [15:0] vector_addr,
    output logic             pc_load_en,
    output logic      [7:0]  psw_restore,
    output logic             psw_restore_en,
    output logic             accept_ack
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and internal signals.
    logic [15:0]   enable_register;
    logic [15:0]   request_latch;
    logic [15:0]   gated_request;
    logic [15:0]   set_pulse;
    logic [15:0]   clear_mask;
    logic          master_irq_enable;
    logic          pick_found;
    logic [3:0]    pick_index;
    logic          soft_pending;
    logic          take_soft;
    logic [3:0]    taken_index;
    logic [15:0]   saved_sp;
    logic [15:0]   saved_pc;
    logic [7:0]    saved_psw;
    logic [2:0]    ret_step;
    logic [15:0]   sw_clear;
    accept_state_t state;
    accept_state_t next_state;

    assign master_irq_enable = enable_register[MASTER_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Shared-source factor selection: unselected factors are simply dropped,
    // since holding them would fire a stale request after the selector moves.
    always_comb
    begin
        set_pulse = source_request;
        set_pulse[9]  = shared_factor_select[SEL_SRC9]  ? alt_factor_request[0]
                                                        : source_request[9];
        set_pulse[14] = shared_factor_select[SEL_SRC14] ? alt_factor_request[1]
                                                        : source_request[14];
        set_pulse[15] = shared_factor_select[SEL_SRC15] ? alt_factor_request[2]
                                                        : source_request[15];
        set_pulse[1:0] = 2'b00;
        set_pulse[TRAP_SRC] = source_request[TRAP_SRC] | (fetch_valid & fetch_in_data_area
                                                          & trap_as_interrupt);
    end

    // Address trap either interrupts or asks for a reset, as the core selects.
    assign trap_reset_req = fetch_valid & fetch_in_data_area & ~trap_as_interrupt;

    // Nonexistent memory reads back as the soft trap opcode.
    assign fetch_data = fetch_nonexistent ? SOFT_TRAP_CODE : mem_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Software clear: a written zero clears, a one leaves the latch alone; latches 2 and 3 never clear this way.
    always_comb
    begin
        sw_clear = 16'h0000;
        if (reg_write && reg_addr == PENDING_LOW_ADDR)
            sw_clear[7:0] = ~reg_wdata;
        if (reg_write && reg_addr == PENDING_HIGH_ADDR)
            sw_clear[15:8] = ~reg_wdata;
        sw_clear = sw_clear & SW_CLEARABLE;
    end

    // Acknowledge clears only the accepted source latch.
    always_comb
    begin
        clear_mask = sw_clear;
        if (accept_ack && !take_soft)
            clear_mask[taken_index] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request latches; a new request in the clearing cycle wins over the clear.
    genvar g;
    generate
        for (g = 0; g < NUM_SOURCES; g++)
        begin : g_latch
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                    request_latch[g] <= PENDING_RESET[g];
                else if (set_pulse[g])
                    request_latch[g] <= 1'b1;
                else if (clear_mask[g])
                    request_latch[g] <= 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Gating: sources 2 and 3 are non-maskable, sources 4 to 15 need master and own flag, 0 and 1 never pass.
    always_comb
    begin
        gated_request = 16'h0000;
        gated_request[TRAP_SRC] = request_latch[TRAP_SRC];
        gated_request[WDT_SRC]  = request_latch[WDT_SRC];
        for (int i = FIRST_MASKABLE; i < NUM_SOURCES; i++)
        begin
            gated_request[i] = request_latch[i] & enable_register[i]
                               & master_irq_enable;
        end
    end

    irq_priority u_priority (
        .request (gated_request),
        .found   (pick_found),
        .index   (pick_index)
    );

    // Soft trap and undefined opcode are remembered until the sequence takes them.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            soft_pending <= 1'b0;
        else if (soft_trap_exec || undef_exec)
            soft_pending <= 1'b1;
        else if (accept_ack && take_soft)
            soft_pending <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acceptance sequence: eight cycles, from the last instruction cycle, or at once for a soft trap or undefined opcode.
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (soft_trap_exec || undef_exec || soft_pending)
                    next_state = ST_CLR;
                else if (instr_last_cycle && pick_found)
                    next_state = ST_CLR;
            end
            ST_CLR:  next_state = ST_PSW;
            ST_PSW:  next_state = ST_PCH;
            ST_PCH:  next_state = ST_PCL;
            ST_PCL:  next_state = ST_VLO;
            ST_VLO:  next_state = ST_VHI;
            ST_VHI:  next_state = ST_JUMP;
            ST_JUMP: next_state = ST_DONE;
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Capture source, PC, SP and status when the sequence starts.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            take_soft   <= 1'b0;
            taken_index <= 4'h0;
            saved_pc    <= 16'h0000;
            saved_sp    <= 16'h0000;
            saved_psw   <= 8'h00;
        end
        else if (state == ST_IDLE && next_state == ST_CLR)
        begin
            take_soft   <= soft_trap_exec | undef_exec | soft_pending;
            taken_index <= pick_index;
            saved_pc    <= pc_now;
            saved_sp    <= sp_load_en ? sp_load : sp_now; // A return may still be raising SP.
            saved_psw   <= {program_status_word[7:1], master_irq_enable};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable registers; master enable is cleared on acceptance, reloaded on return.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            enable_register <= ENABLE_RESET;
        end
        else
        begin
            if (reg_write && reg_addr == ENABLE_LOW_ADDR)
                enable_register[7:0] <= reg_wdata;
            if (reg_write && reg_addr == ENABLE_HIGH_ADDR)
                enable_register[15:8] <= reg_wdata;
            if (state == ST_CLR)
                enable_register[MASTER_BIT] <= 1'b0;
            else if (psw_restore_en)
                enable_register[MASTER_BIT] <= stack_rdata[MASTER_BIT];
        end
    end

    assign accept_ack  = (state == ST_CLR);
    assign accept_busy = (state != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Stack pushes: status at SP, PC high at SP-1, PC low at SP-2, so afterward
    // the low byte sits at new SP+1 and the high byte at new SP+2.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            stack_write <= 1'b0;
            stack_addr  <= 16'h0000;
            stack_wdata <= 8'h00;
            sp_load     <= 16'h0000;
            sp_load_en  <= 1'b0;
            vector_addr <= 16'h0000;
            pc_load_en  <= 1'b0;
        end
        else
        begin
            stack_write <= (state == ST_PSW) || (state == ST_PCH) || (state == ST_PCL);
            sp_load_en  <= 1'b0;
            pc_load_en  <= 1'b0;
            case (state)
                ST_PSW:
                begin
                    stack_addr  <= saved_sp;
                    stack_wdata <= saved_psw;
                end
                ST_PCH:
                begin
                    stack_addr  <= saved_sp - 16'h0001;
                    stack_wdata <= saved_pc[15:8];
                end
                ST_PCL:
                begin
                    stack_addr  <= saved_sp - 16'h0002;
                    stack_wdata <= saved_pc[7:0];
                    sp_load     <= saved_sp - STACK_FRAME;
                    sp_load_en  <= 1'b1;
                end
                ST_JUMP:
                begin
                    vector_addr <= take_soft ? SOFT_VECTOR
                                             : VECTOR_TOP - {11'h000, taken_index, 1'b0};
                    pc_load_en  <= 1'b1;
                end
                ST_IDLE:
                begin
                    if (ret_step == 3'h3)
                    begin
                        sp_load    <= sp_now + STACK_FRAME;
                        sp_load_en <= 1'b1;
                    end
                end
                default:     stack_addr  <= stack_addr;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Return: the core pops PC itself; status pop is flagged at the third step.
    // Both return kinds behave alike here; picking the right one is software's job.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ret_step <= 3'h0;
        else if (maskable_return || nonmaskable_return)
            ret_step <= 3'h1;
        else if (ret_step != 3'h0)
            ret_step <= (ret_step == 3'h3) ? 3'h0 : ret_step + 3'h1;
    end

    assign psw_restore_en = (ret_step == 3'h3);
    assign psw_restore    = stack_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Register reads return live pending state and enables.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            case (reg_addr)
                ENABLE_LOW_ADDR:   reg_rdata <= enable_register[7:0];
                ENABLE_HIGH_ADDR:  reg_rdata <= enable_register[15:8];
                PENDING_LOW_ADDR:  reg_rdata <= request_latch[7:0];
                PENDING_HIGH_ADDR: reg_rdata <= request_latch[15:8];
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// *** verilog/irq_ctrl_pkg.sv ***
// Package of register offsets, field positions, vectors and sequence timing for the interrupt controller.
package irq_ctrl_pkg;

    // Register addresses inside the special function area.
    localparam logic [7:0] ENABLE_LOW_ADDR   = 8'h3A;
    localparam logic [7:0] ENABLE_HIGH_ADDR  = 8'h3B;
    localparam logic [7:0] PENDING_LOW_ADDR  = 8'h3C;
    localparam logic [7:0] PENDING_HIGH_ADDR = 8'h3D;

    // Field positions and reset values.
    localparam int          MASTER_BIT      = 0;
    localparam int          FIRST_MASKABLE  = 4;
    localparam int          NUM_SOURCES     = 16;
    localparam int          WDT_SRC         = 3;
    localparam int          TRAP_SRC        = 2;
    localparam logic [15:0] ENABLE_RESET    = 16'h0000;
    localparam logic [15:0] PENDING_RESET   = 16'h0000;
    localparam logic [15:0] SW_CLEARABLE    = 16'hFFF3;

    // Shared sources and their selector bit positions.
    localparam int          SEL_SRC9        = 0;
    localparam int          SEL_SRC14       = 1;
    localparam int          SEL_SRC15       = 2;
    localparam logic [2:0]  SELECT_RESET    = 3'h0;

    // Vector base: source n uses FFFE minus 2n; soft trap shares FFFC.
    localparam logic [15:0] VECTOR_TOP      = 16'hFFFE;
    localparam logic [15:0] SOFT_VECTOR     = 16'hFFFC;
    localparam logic [15:0] STACK_FRAME     = 16'h0003;
    localparam logic [7:0]  SOFT_TRAP_CODE  = 8'hFF;

    // Acceptance sequence length in machine cycles.
    localparam int          ACCEPT_CYCLES   = 8;

    // Acceptance sequence states, Gray coded from IDLE to DONE; DONE back to IDLE changes two bits.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_CLR   = 4'b0001,
        ST_PSW   = 4'b0011,
        ST_PCH   = 4'b0010,
        ST_PCL   = 4'b0110,
        ST_VLO   = 4'b0111,
        ST_VHI   = 4'b0101,
        ST_JUMP  = 4'b0100,
        ST_DONE  = 4'b1100
    } accept_state_t;

endpackage

// *** verilog/irq_priority.sv ***
// Fixed-priority pick of the lowest-numbered requesting interrupt source.
`timescale 1ns/1ns
module irq_priority
    import irq_ctrl_pkg::*;
(
    input  wire logic [15:0] request,
    output logic             found,
    output logic [3:0]       index
);

    // Lowest source number wins; scanning downward lets it overwrite the others.
    always_comb
    begin
        found = 1'b0;
        index = 4'h0;
        for (int i = NUM_SOURCES - 1; i >= TRAP_SRC; i--)
        begin
            if (request[i])
            begin
                found = 1'b1;
                index = 4'(i);
            end
        end
    end

endmodule
